// ===== core/gpr_pkg.sv
`default_nettype none

package gpr_pkg;

    // special-function addresses
    localparam logic [7:0] ADDR_PORT5_OUTPUT_TYPE    = 8'h9B;
    localparam logic [7:0] ADDR_PORT6_OUTPUT_TYPE    = 8'h9C;
    localparam logic [7:0] ADDR_PORT6_LATCH_AND_PINS = 8'hB2;
    localparam logic [7:0] ADDR_PORT5_LATCH_AND_PINS = 8'hB3;
    localparam logic [7:0] ADDR_PORT5_ANALOG_SELECT  = 8'hF6;
    localparam logic [7:0] ADDR_PORT6_ANALOG_SELECT  = 8'hF7;
    localparam logic [7:0] ADDR_PORT4_DRIVE_SELECT   = 8'hFD;
    localparam logic [7:0] ADDR_PORT5_DRIVE_SELECT   = 8'hFE;

    // page holding the configuration registers
    localparam logic [7:0] CONFIG_PAGE = 8'h0F;

    // reset values
    localparam logic [7:0] RST_PORT5_LATCH  = 8'hFF;
    localparam logic [5:0] RST_PORT6_LATCH  = 6'h3F;
    localparam logic [7:0] RST_PORT5_ANALOG = 8'hFF;
    localparam logic [5:0] RST_PORT6_ANALOG = 6'h3F;
    localparam logic [7:0] RST_PORT5_OTYPE  = 8'h00;
    localparam logic [5:0] RST_PORT6_OTYPE  = 6'h00;
    localparam logic [7:0] RST_PORT4_DRIVE  = 8'h00;
    localparam logic [7:0] RST_PORT5_DRIVE  = 8'h00;

    // six-pin port width and padding of its unused upper bits
    localparam int         PORT6_PINS   = 6;
    localparam logic [1:0] PORT6_UNUSED = 2'h0;

    // register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] page;
    } gpr_req_t;

    // per-pin controls to the pad cells of one port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pullup_en;
        logic [7:0] rx_en;
        logic [7:0] hi_drive;
    } gpr_pad_t;

endpackage

`default_nettype wire

// ===== core/gpr_port_regs.sv
`timescale 1ns/1ps
`default_nettype none

module gpr_port_regs
(
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    // register bus
    input  wire gpr_pkg::gpr_req_t i_req,
    output var  logic [7:0]        o_rdata,
    output var  logic              o_hit,
    // pins
    input  wire logic [7:0]        i_port5_pin,
    input  wire logic [5:0]        i_port6_pin,
    output var  gpr_pkg::gpr_pad_t o_port5_pad,
    output var  gpr_pkg::gpr_pad_t o_port6_pad,
    output var  logic [7:0]        o_port4_hi_drive
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] port5_latch_reg;
    logic [5:0] port6_latch_reg;
    logic [7:0] port5_analog_reg;
    logic [5:0] port6_analog_reg;
    logic [7:0] port5_otype_reg;
    logic [5:0] port6_otype_reg;
    logic [7:0] port4_drive_reg;
    logic [7:0] port5_drive_reg;
    logic [7:0] port5_meta_reg;
    logic [7:0] port5_sync_reg;
    logic [5:0] port6_meta_reg;
    logic [5:0] port6_sync_reg;
    logic       cfg_page;
    logic [7:0] rdata_next;
    logic       hit_next;

    assign cfg_page = (i_req.page == gpr_pkg::CONFIG_PAGE);

    // pad controls for one 8-bit slice; bit n drives pin n
    function automatic gpr_pkg::gpr_pad_t pad_ctl(
        input logic [7:0] latch,
        input logic [7:0] digital,
        input logic [7:0] push_pull,
        input logic [7:0] drive
    );
        gpr_pkg::gpr_pad_t p;
        p.out       = latch & digital;
        // open-drain drives only a low; analog never drives
        p.oe        = digital & (push_pull | ~latch);
        p.pullup_en = digital & ~push_pull & latch;
        p.rx_en     = digital;
        p.hi_drive  = drive;
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // data latches, visible on every page
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            port5_latch_reg <= gpr_pkg::RST_PORT5_LATCH;
            port6_latch_reg <= gpr_pkg::RST_PORT6_LATCH;
        end
        else if (i_req.wr)
        begin
            if (i_req.addr == gpr_pkg::ADDR_PORT5_LATCH_AND_PINS)
                port5_latch_reg <= i_req.wdata;
            if (i_req.addr == gpr_pkg::ADDR_PORT6_LATCH_AND_PINS)
                port6_latch_reg <= i_req.wdata[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers, page F only
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            port5_analog_reg <= gpr_pkg::RST_PORT5_ANALOG;
            port6_analog_reg <= gpr_pkg::RST_PORT6_ANALOG;
            port5_otype_reg  <= gpr_pkg::RST_PORT5_OTYPE;
            port6_otype_reg  <= gpr_pkg::RST_PORT6_OTYPE;
            port4_drive_reg  <= gpr_pkg::RST_PORT4_DRIVE;
            port5_drive_reg  <= gpr_pkg::RST_PORT5_DRIVE;
        end
        else if (i_req.wr && cfg_page)
        begin
            case (i_req.addr)
                gpr_pkg::ADDR_PORT5_ANALOG_SELECT:
                    port5_analog_reg <= i_req.wdata;
                gpr_pkg::ADDR_PORT6_ANALOG_SELECT:
                    port6_analog_reg <= i_req.wdata[5:0];
                gpr_pkg::ADDR_PORT5_OUTPUT_TYPE:
                    port5_otype_reg  <= i_req.wdata;
                gpr_pkg::ADDR_PORT6_OUTPUT_TYPE:
                    port6_otype_reg  <= i_req.wdata[5:0];
                gpr_pkg::ADDR_PORT4_DRIVE_SELECT:
                    port4_drive_reg  <= i_req.wdata;
                gpr_pkg::ADDR_PORT5_DRIVE_SELECT:
                    port5_drive_reg  <= i_req.wdata;
                default:
                    port4_drive_reg  <= port4_drive_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            port5_meta_reg <= 8'h00;
            port5_sync_reg <= 8'h00;
            port6_meta_reg <= 6'h00;
            port6_sync_reg <= 6'h00;
        end
        else
        begin
            port5_meta_reg <= i_port5_pin;
            port5_sync_reg <= port5_meta_reg;
            port6_meta_reg <= i_port6_pin;
            port6_sync_reg <= port6_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read decode; unmapped or off-page reads answer zero with no hit
    always_comb
    begin
        rdata_next = 8'h00;
        hit_next   = 1'b1;
        case (i_req.addr)
            gpr_pkg::ADDR_PORT5_LATCH_AND_PINS:
                rdata_next = port5_sync_reg;
            gpr_pkg::ADDR_PORT6_LATCH_AND_PINS:
                rdata_next = {gpr_pkg::PORT6_UNUSED, port6_sync_reg};
            gpr_pkg::ADDR_PORT5_ANALOG_SELECT:
                rdata_next = port5_analog_reg;
            gpr_pkg::ADDR_PORT6_ANALOG_SELECT:
                rdata_next = {gpr_pkg::PORT6_UNUSED, port6_analog_reg};
            gpr_pkg::ADDR_PORT5_OUTPUT_TYPE:
                rdata_next = port5_otype_reg;
            gpr_pkg::ADDR_PORT6_OUTPUT_TYPE:
                rdata_next = {gpr_pkg::PORT6_UNUSED, port6_otype_reg};
            gpr_pkg::ADDR_PORT4_DRIVE_SELECT:
                rdata_next = port4_drive_reg;
            gpr_pkg::ADDR_PORT5_DRIVE_SELECT:
                rdata_next = port5_drive_reg;
            default:
                hit_next = 1'b0;
        endcase
        if (i_req.addr != gpr_pkg::ADDR_PORT5_LATCH_AND_PINS &&
            i_req.addr != gpr_pkg::ADDR_PORT6_LATCH_AND_PINS && !cfg_page)
        begin
            rdata_next = 8'h00;
            hit_next   = 1'b0;
        end
        if (!i_req.rd)
        begin
            rdata_next = 8'h00;
            hit_next   = 1'b0;
        end
    end

    // read answer registered one cycle after the request
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_rdata <= 8'h00;
            o_hit   <= 1'b0;
        end
        else
        begin
            o_rdata <= rdata_next;
            o_hit   <= hit_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pad controls registered so every output comes from a flip-flop
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_port5_pad      <= '0;
            o_port6_pad      <= '0;
            o_port4_hi_drive <= 8'h00;
        end
        else
        begin
            o_port5_pad      <= pad_ctl(port5_latch_reg, port5_analog_reg,
                                        port5_otype_reg, port5_drive_reg);
            // unused pins 7:6 of the six-pin port are held analog, undriven
            o_port6_pad      <= pad_ctl({2'h0, port6_latch_reg},
                                        {2'h0, port6_analog_reg},
                                        {2'h0, port6_otype_reg}, 8'h00);
            o_port4_hi_drive <= port4_drive_reg;
        end
    end

endmodule // gpr_port_regs

`default_nettype wire

// ===== test/gpr_port_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module gpr_monitor (
    // clock and reset
    input wire logic              i_mclk,
    input wire logic              i_sys_rst,
    // register bus
    input wire gpr_pkg::gpr_req_t i_req,
    input wire logic [7:0]        o_rdata,
    input wire logic              o_hit,
    // pins and pads
    input wire logic [7:0]        i_port5_pin,
    input wire logic [5:0]        i_port6_pin,
    input wire gpr_pkg::gpr_pad_t o_port5_pad,
    input wire gpr_pkg::gpr_pad_t o_port6_pad,
    input wire logic [7:0]        o_port4_hi_drive
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    sequence s_rd(a);
        i_req.rd && i_req.addr == a;
    endsequence
    sequence s_cw(a);
        i_req.wr && i_req.addr == a && i_req.page == 8'h0F;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    property p_latch;
        i_req.wr && i_req.addr == 8'hB3 |-> ##2 o_port5_pad.out ==
            ($past(i_req.wdata, 2) & o_port5_pad.rx_en);
    endproperty
    a_latch: assert property (p_latch) else $error("latch");
    // two synchroniser stages plus the registered answer: exactly 3 edges
    property p_pin;
        s_rd(8'hB3) |=> o_hit && o_rdata == $past(i_port5_pin, 3);
    endproperty
    a_pin: assert property (p_pin) else $error("pin read");
    property p_p6rd;
        s_rd(8'hB2) |=> o_hit && o_rdata[7:6] == 2'h0;
    endproperty
    a_p6rd: assert property (p_p6rd) else $error("p6 read");
    property p_page;
        i_req.rd && i_req.page != 8'h0F && i_req.addr[7:4] == 4'hF
            |=> !o_hit && o_rdata == 8'h00;
    endproperty
    a_page: assert property (p_page) else $error("off page");
    property p_ana;
        s_cw(8'hF6) |-> ##2 o_port5_pad.rx_en == $past(i_req.wdata, 2);
    endproperty
    a_ana: assert property (p_ana) else $error("analog sel");
    property p_anaoff;
        (~o_port5_pad.rx_en & (o_port5_pad.oe | o_port5_pad.pullup_en))
            == 8'h00;
    endproperty
    a_anaoff: assert property (p_anaoff)
        else $error("analog");
    property p_od;
        ((o_port5_pad.rx_en & ~o_port5_pad.out & ~o_port5_pad.oe)
            | (o_port5_pad.out & ~(o_port5_pad.oe ^ o_port5_pad.pullup_en)))
            == 8'h00;
    endproperty
    a_od: assert property (p_od) else $error("out type");
    property p_drv;
        s_cw(8'hFE) |-> ##2 o_port5_pad.hi_drive == $past(i_req.wdata, 2);
    endproperty
    a_drv: assert property (p_drv) else $error("drive");
    property p_rst;
        $fell(i_sys_rst) |=> o_port5_pad.rx_en == 8'hFF
            && o_port5_pad.out == 8'hFF && o_port4_hi_drive == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("reset cfg");
endmodule // gpr_monitor
bind gpr_port_regs gpr_monitor i_gpr_monitor (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_req(i_req), .o_rdata(o_rdata), .o_hit(o_hit),
    .i_port5_pin(i_port5_pin), .i_port6_pin(i_port6_pin),
    .o_port5_pad(o_port5_pad), .o_port6_pad(o_port6_pad),
    .o_port4_hi_drive(o_port4_hi_drive));
`default_nettype wire

// ===== test/gpr_board.sv
`timescale 1ns/1ps
`default_nettype none
module gpr_board (
    // pad controls and far-side source
    input  wire gpr_pkg::gpr_pad_t i_pad,
    input  wire logic [7:0]        i_ext,
    // resolved pin level
    output wire logic [7:0]        o_pin
);
    // an undriven pin with pullup floats high, else the far side wins
    assign o_pin = (i_pad.oe & i_pad.out)
        | (~i_pad.oe & (i_pad.pullup_en | i_ext));
endmodule // gpr_board
`default_nettype wire

// ===== test/test_port_data_and_pin_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_port_data_and_pin_config_regs;
    logic              i_mclk = 1'b0;
    logic              i_sys_rst = 1'b1;
    gpr_pkg::gpr_req_t i_req = '0;
    gpr_pkg::gpr_pad_t pad5, pad6;
    logic [7:0]        o_rdata, p5, p6, p4, ext5 = 8'h00, ext6 = 8'h00;
    logic              o_hit;
    logic [7:0]        l5 = 8'hFF, d5 = 8'hFF, t5 = 8'h00, v5 = 8'h00;
    logic [7:0]        l6 = 8'h3F, d6 = 8'h3F, t6 = 8'h00, v4 = 8'h00;
    logic [7:0]        pg = 8'h0F;
    int                mismatches = 0, n_checks = 0;
    always #20 i_mclk = ~i_mclk;
    gpr_port_regs i_gpr_port_regs (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_req(i_req), .o_rdata(o_rdata), .o_hit(o_hit), .i_port5_pin(p5),
        .i_port6_pin(p6[5:0]), .o_port5_pad(pad5), .o_port6_pad(pad6),
        .o_port4_hi_drive(p4));
    gpr_board i_board5 (.i_pad(pad5), .i_ext(ext5), .o_pin(p5));
    gpr_board i_board6 (.i_pad(pad6), .i_ext(ext6), .o_pin(p6));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [39:0] pad_x(input logic [7:0] l, d, t, v);
        return {l & d, d & (t | ~l), d & ~t & l, d, v};
    endfunction
    task automatic chk(input logic [39:0] g, e);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic op(input logic w, input logic [7:0] a, d, p);
        i_req <= '{w, ~w, a, d, p};
        @(posedge i_mclk);
    endtask
    task automatic rd(input logic [7:0] a, p, e, input logic h);
        op(1'b0, a, 8'h00, p);
        #1 chk({31'h0, o_hit, o_rdata}, {31'h0, h, e});
        @(posedge i_mclk);
    endtask
    // pins need the pad update plus two synchroniser stages to settle
    task automatic check_all();
        i_req <= '0;
        repeat (4) @(posedge i_mclk);
        chk(pad5, pad_x(l5, d5, t5, v5));
        chk(pad6, pad_x(l6, d6, t6, 8'h00));
        chk({32'h0, p4}, {32'h0, v4});
        rd(8'hB3, pg, (d5 & l5) | (~d5 & ext5), 1'b1);
        rd(8'hB2, pg, (d6 & l6) | (~d6 & ext6 & 8'h3F), 1'b1);
        rd(8'hF6, 8'h0F, d5, 1'b1);
        rd(8'hF7, 8'h0F, d6, 1'b1);
        rd(8'h9B, 8'h0F, t5, 1'b1);
        rd(8'h9C, 8'h0F, t6, 1'b1);
        rd(8'hFD, 8'h0F, v4, 1'b1);
        rd(8'hFE, 8'h0F, v5, 1'b1);
        rd(8'hFE, 8'h00, 8'h00, 1'b0);
        rd(8'h55, 8'h0F, 8'h00, 1'b0);
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h48A3));
        repeat (5) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        check_all();
        for (int i = 0; i < 40; i++)
        begin
            {l5, d5, t5, v5} = $urandom;
            {l6, d6, t6, v4} = $urandom;
            if (i == 0) {d5, t5} = 16'h00FF;
            if (i == 1) {l5, d5, t5} = 24'hFFFF00;
            pg = i[0] ? 8'h0F : 8'($urandom);
            {ext5, ext6} <= 16'($urandom);
            op(1'b1, 8'hB3, l5, pg);
            op(1'b1, 8'hB2, l6, pg);
            op(1'b1, 8'hF6, d5, 8'h0F);
            op(1'b1, 8'hF7, d6, 8'h0F);
            op(1'b1, 8'h9B, t5, 8'h0F);
            op(1'b1, 8'h9C, t6, 8'h0F);
            op(1'b1, 8'hFD, v4, 8'h0F);
            op(1'b1, 8'hFE, v5, 8'h0F);
            op(1'b1, 8'hF6, ~d5, 8'h0E);
            op(1'b1, 8'hFD, ~v4, 8'h03);
            {l6[7:6], d6[7:6], t6[7:6]} = 6'h00;
            check_all();
        end
        report_and_stop();
    end
endmodule // test_port_data_and_pin_config_regs
`default_nettype wire
